// [dv/lpms_top_tb.sv]
/*
 lpms_top_tb: self-checking bench for the lighting power mode sequencer,
 one hand-written task per scenario. Assumes the design's own embedded
 assertions and shortened startup and soft-start counts set below.
*/
`timescale 1ns/10ps
module lpms_top_tb;
    localparam int SU = 20;
    localparam int SS = 30;

    logic       ref_clk;
    logic       arst_n;
    logic       ext_pin_n;
    logic       thermal;
    logic       peak;
    logic       oc;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [4:0] mode_state;
    logic       analog_en;
    logic       boost_run;
    logic       boost_low;
    logic       boost_sw;
    logic       led_blank;
    logic       load_en;
    logic [7:0] vout_code;
    int         n_errors;
    int         checked;
    int         sw_hi;
    int         n;

    lpms_top #(.STARTUP_CYCLES(SU), .SOFTSTART_CYCLES(SS)) DUT (
        .REF_CLK(ref_clk), .ARST_N(arst_n), .EXT_RESET_PIN_N(ext_pin_n), .THERMAL_TRIP(thermal),
        .PEAK_REACHED(peak), .OVERCURRENT(oc), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .MODE_STATE(mode_state), .ANALOG_EN(analog_en),
        .BOOST_RUN(boost_run), .BOOST_LOW_CURRENT(boost_low), .BOOST_SW(boost_sw), .LED_BLANK(led_blank),
        .ACTIVE_LOAD_EN(load_en), .VOUT_CODE(vout_code)
    );

    always #12.5 ref_clk = ~ref_clk;

    task automatic end_of_test();
        $display("errors %0d, comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // inputs move 2 ns after the edge so no race with the sampling edge
    task automatic tick();
        @(posedge ref_clk);
        #2;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        tick();
        reg_wr = 1'b0;
        tick();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_rd   = 1'b1;
        reg_addr = a;
        tick();
        reg_rd = 1'b0;
        tick();
        chk(reg_rdata, exp);
    endtask : rd

    // bounded wait for a state; also tallies switch-on cycles on the way
    task automatic wait_st(input logic [4:0] s, input int bound, output int cnt);
        cnt   = 0;
        sw_hi = 0;
        while (mode_state !== s) begin
            if (boost_sw === 1'b1) sw_hi++;
            tick();
            cnt++;
            if (cnt > bound) begin
                n_errors++;
                $display("[ERR] %0t state %h never reached", $time, s);
                end_of_test();
            end
        end
    endtask : wait_st

    // width of the next whole switch pulse, bounded
    task automatic pw(output int w);
        int k;
        k = 0;
        w = 0;
        while (boost_sw !== 1'b0 && k < 50) begin tick(); k++; end
        while (boost_sw !== 1'b1 && k < 100) begin tick(); k++; end
        while (boost_sw === 1'b1 && w < 50) begin tick(); w++; end
        if (k >= 100) begin
            n_errors++;
            $display("[ERR] %0t switch pulse missing", $time);
        end
    endtask : pw

    task automatic t_reset_values();
        chk({3'h0, mode_state}, 8'h01);
        chk(vout_code, lpms_pkg::VOUT_RESET);
        wait_st(5'h02, 10, n);
        chk({analog_en, boost_run, led_blank, boost_sw}, 8'h00);
        rd(lpms_pkg::ADDR_VOUT, lpms_pkg::VOUT_RESET);
        rd(lpms_pkg::ADDR_MODE, lpms_pkg::MODE_RESET);
        rd(lpms_pkg::ADDR_STATUS, 8'h02);
        rd(8'h30, 8'h00);
    endtask : t_reset_values

    task automatic t_vout_clamp();
        logic [7:0] w [6] = '{8'h03, 8'h08, 8'h0c, 8'h14, 8'h15, 8'hff};
        logic [7:0] e [6] = '{8'h08, 8'h08, 8'h0c, 8'h14, 8'h14, 8'h14};
        for (int i = 0; i < 6; i++) begin
            wr(lpms_pkg::ADDR_VOUT, w[i]);
            tick();
            chk(vout_code, e[i]);
            rd(lpms_pkg::ADDR_VOUT, w[i]);
        end
        wr(lpms_pkg::ADDR_VOUT, 8'h08);
    endtask : t_vout_clamp

    task automatic t_startup();
        wr(lpms_pkg::ADDR_MODE, 8'h06);
        repeat (5) tick();
        chk({analog_en, 2'h0, mode_state}, 8'h02);
        wr(lpms_pkg::ADDR_MODE, 8'h07);
        wait_st(5'h04, 4, n);
        chk(analog_en, 1'b1);
        wait_st(5'h08, SU + 5, n);
        chk(8'(n >= SU - 3 && n <= SU + 2), 8'h01);
        chk({boost_run, boost_low, led_blank}, 8'h07);
        wait_st(5'h10, SS + 5, n);
        chk(8'(n >= SS - 3 && n <= SS + 2), 8'h01);
        chk(8'(sw_hi), 8'(lpms_pkg::SOFT_ON_CYC));
        chk({boost_run, boost_low, led_blank}, 8'h04);
    endtask : t_startup

    task automatic t_switch();
        int w;
        pw(w);
        chk(8'(w), 8'(lpms_pkg::MAX_ON_CYC));
        peak = 1'b1;
        pw(w);
        pw(w);
        chk(8'(w), 8'(lpms_pkg::MIN_ON_CYC));
        peak = 1'b0;
        pw(w);
        while (boost_sw !== 1'b1 && w < 100) begin tick(); w++; end
        repeat (3) tick();
        chk(boost_sw, 1'b1);
        oc = 1'b1;
        w  = 0;
        while (boost_sw === 1'b1 && w < 10) begin tick(); w++; end
        chk(8'(w <= 4), 8'h01);
        oc = 1'b0;
    endtask : t_switch

    task automatic t_active_load();
        wr(lpms_pkg::ADDR_MODE, 8'h03);
        tick();
        chk(load_en, 1'b0);
        chk({3'h0, mode_state}, 8'h10);
        wr(lpms_pkg::ADDR_MODE, 8'h07);
        tick();
        chk(load_en, 1'b1);
    endtask : t_active_load

    task automatic t_thermal();
        thermal = 1'b1;
        wait_st(5'h04, 6, n);
        repeat (2 * SU) tick();
        chk({3'h0, mode_state}, 8'h04);
        chk(boost_run, 1'b0);
        thermal = 1'b0;
        wait_st(5'h08, SU + 8, n);
        wait_st(5'h10, SS + 8, n);
    endtask : t_thermal

    task automatic t_boost_toggle();
        wr(lpms_pkg::ADDR_MODE, 8'h05);
        repeat (3) tick();
        chk({boost_run, boost_sw}, 8'h00);
        wr(lpms_pkg::ADDR_MODE, 8'h07);
        wait_st(5'h08, 6, n);
        chk(led_blank, 1'b1);
        // clearing the enable in mid soft start drops to normal with boost off
        wr(lpms_pkg::ADDR_MODE, 8'h05);
        chk({3'h0, mode_state}, 8'h10);
        chk(boost_run, 1'b0);
        wr(lpms_pkg::ADDR_MODE, 8'h07);
        wait_st(5'h08, 6, n);
        wait_st(5'h10, SS + 8, n);
    endtask : t_boost_toggle

    task automatic t_exit_and_pin();
        wr(lpms_pkg::ADDR_MODE, 8'h06);
        wait_st(5'h02, 4, n);
        chk({analog_en, boost_run}, 8'h00);
        wr(lpms_pkg::ADDR_VOUT, 8'h10);
        ext_pin_n = 1'b0;
        repeat (4) tick();
        chk({3'h0, mode_state}, 8'h01);
        chk(vout_code, lpms_pkg::VOUT_RESET);
        ext_pin_n = 1'b1;
        wait_st(5'h02, 10, n);
        rd(lpms_pkg::ADDR_VOUT, lpms_pkg::VOUT_RESET);
        rd(lpms_pkg::ADDR_MODE, lpms_pkg::MODE_RESET);
    endtask : t_exit_and_pin

    initial begin
        ref_clk   = 1'b0;
        arst_n    = 1'b0;
        ext_pin_n = 1'b1;
        thermal   = 1'b0;
        peak      = 1'b0;
        oc        = 1'b0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        n_errors  = 0;
        checked   = 0;
        repeat (2) tick();
        arst_n = 1'b1;
        t_reset_values();
        t_vout_clamp();
        t_startup();
        t_switch();
        t_active_load();
        t_thermal();
        t_boost_toggle();
        t_exit_and_pin();
        end_of_test();
    end
endmodule : lpms_top_tb

// [rtl/lpms_pkg.sv]
/*
 lpms_pkg: constants, register map and mode encoding of the lighting power
 mode sequencer. Assumes a single 40 MHz reference clock that stands for the
 internal resistor-set oscillator.
*/
package lpms_pkg;
    // clock and timing
    localparam int REF_CLK_HZ         = 40_000_000;
    localparam int CLK_PERIOD_NS      = 25;
    localparam int STARTUP_DELAY_MS   = 10;
    localparam int SOFTSTART_DELAY_MS = 20;
    localparam int STARTUP_CYC        = STARTUP_DELAY_MS * (REF_CLK_HZ / 1000);
    localparam int SOFTSTART_CYC      = SOFTSTART_DELAY_MS * (REF_CLK_HZ / 1000);
    localparam int CNT_W              = 20;

    // boost switching
    localparam int BOOST_FREQ_HZ      = 1_000_000;
    localparam int PERIOD_CYC         = REF_CLK_HZ / BOOST_FREQ_HZ;
    localparam int MIN_PULSE_NS       = 45;
    localparam int MIN_ON_CYC         = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MAX_DUTY_PCT       = 90;
    localparam int MAX_ON_CYC         = (PERIOD_CYC * MAX_DUTY_PCT) / 100;
    localparam int SOFT_ON_CYC        = 8;
    localparam int PCNT_W             = 6;

    // register map
    localparam logic [7:0] ADDR_VOUT   = 8'h0d;
    localparam logic [7:0] ADDR_MODE   = 8'h0e;
    localparam logic [7:0] ADDR_STATUS = 8'h0f;
    localparam logic [7:0] VOUT_RESET  = 8'h08;
    localparam logic [7:0] VOUT_MIN    = 8'h08;
    localparam logic [7:0] VOUT_MAX    = 8'h14;
    localparam int         MODE_STBY_EXIT = 0;
    localparam int         MODE_BOOST_EN  = 1;
    localparam int         MODE_AUTOLOAD  = 2;
    localparam logic [7:0] MODE_RESET  = 8'h04;
    localparam logic [7:0] MODE_MASK   = 8'h07;

    typedef enum logic [4:0] {
        ST_RESET       = 5'h01,
        ST_STANDBY     = 5'h02,
        ST_STARTUP     = 5'h04,
        ST_BOOST_START = 5'h08,
        ST_NORMAL      = 5'h10
    } lpms_state_t;
endpackage : lpms_pkg

// [rtl/lpms_pulse_gen.sv]
/*
 lpms_pulse_gen: per-period boost switch pulse with minimum width, duty
 limit, soft-start cap and over-current cut-off. Assumes peak and over-current
 inputs are already synchronised to clk.
*/
`timescale 1ns/10ps
module lpms_pulse_gen (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic enable,
    input  wire logic low_current,
    input  wire logic skip_ok,
    input  wire logic peak,
    input  wire logic overcurrent,
    output logic      sw_on
);
    typedef struct packed {
        logic [lpms_pkg::PCNT_W-1:0] pcnt;
        logic                        sw;
    } lpms_pg_t;

    localparam logic [lpms_pkg::PCNT_W-1:0] P_LAST = lpms_pkg::PCNT_W'(lpms_pkg::PERIOD_CYC - 1);
    localparam logic [lpms_pkg::PCNT_W-1:0] P_MIN  = lpms_pkg::PCNT_W'(lpms_pkg::MIN_ON_CYC);
    localparam logic [lpms_pkg::PCNT_W-1:0] P_MAX  = lpms_pkg::PCNT_W'(lpms_pkg::MAX_ON_CYC);
    localparam logic [lpms_pkg::PCNT_W-1:0] P_SOFT = lpms_pkg::PCNT_W'(lpms_pkg::SOFT_ON_CYC);

    lpms_pg_t r;
    lpms_pg_t next_r;
    logic [lpms_pkg::PCNT_W-1:0] np;
    logic [lpms_pkg::PCNT_W-1:0] on_limit;

    always_comb begin
        next_r   = r;
        np       = (r.pcnt == P_LAST) ? '0 : r.pcnt + 1'b1;
        on_limit = low_current ? P_SOFT : P_MAX;
        if (!enable) begin
            // parked on the last count so the first enabled cycle opens a period
            next_r.pcnt = P_LAST;
            next_r.sw   = 1'b0;
        end else begin
            next_r.pcnt = np;
            if (overcurrent) begin
                next_r.sw = 1'b0;
            end else if (np == '0) begin
                // skipping only allowed with the active load off
                next_r.sw = !(skip_ok && peak);
            end else if (np < P_MIN) begin
                next_r.sw = r.sw;
            end else if (np >= on_limit) begin
                next_r.sw = 1'b0;
            end else if (peak) begin
                next_r.sw = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign sw_on = r.sw;

    a_min_pulse: assert property (@(posedge clk) disable iff (!arst_n)
        (r.sw && r.pcnt == '0 && enable && !overcurrent) |=> r.sw)
        else $error("switch pulse shorter than minimum");
    a_oc_cutoff: assert property (@(posedge clk) disable iff (!arst_n)
        overcurrent |=> !r.sw)
        else $error("switch stayed on under over-current");
    a_duty_limit: assert property (@(posedge clk) disable iff (!arst_n)
        r.sw |-> (r.pcnt < P_MAX))
        else $error("duty cycle limit exceeded");
    a_soft_cap: assert property (@(posedge clk) disable iff (!arst_n)
        low_current |=> !(r.sw && r.pcnt >= P_SOFT))
        else $error("soft-start on time exceeded");
    a_no_skip: assert property (@(posedge clk) disable iff (!arst_n)
        (enable && !skip_ok && !overcurrent && r.pcnt == P_LAST) |=> r.sw)
        else $error("pulse skipped with active load on");
endmodule : lpms_pulse_gen

// [rtl/lpms_top.sv]
/*
 lpms_top: operating-mode sequencer with register file and boost digital
 control. Assumes an external serial front end turning bus traffic into
 one-cycle register read and write strobes on REF_CLK, and analog pins
 (reset pin, thermal trip, peak current, over-current) asynchronous to it.
*/
`timescale 1ns/10ps
module lpms_top #(
    parameter int STARTUP_CYCLES   = lpms_pkg::STARTUP_CYC,
    parameter int SOFTSTART_CYCLES = lpms_pkg::SOFTSTART_CYC
) (
    input  wire logic        REF_CLK,
    input  wire logic        ARST_N,
    input  wire logic        EXT_RESET_PIN_N,
    input  wire logic        THERMAL_TRIP,
    input  wire logic        PEAK_REACHED,
    input  wire logic        OVERCURRENT,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    output logic      [7:0]  REG_RDATA,
    output logic      [4:0]  MODE_STATE,
    output logic             ANALOG_EN,
    output logic             BOOST_RUN,
    output logic             BOOST_LOW_CURRENT,
    output logic             BOOST_SW,
    output logic             LED_BLANK,
    output logic             ACTIVE_LOAD_EN,
    output logic      [7:0]  VOUT_CODE
);
    typedef struct packed {
        logic [1:0]            rst_sync;
        logic [1:0]            tsd_sync;
        logic [1:0]            pk_sync;
        logic [1:0]            oc_sync;
        lpms_pkg::lpms_state_t state;
        logic [lpms_pkg::CNT_W-1:0] cnt;
        logic [7:0]            vout_reg;
        logic [7:0]            mode_reg;
        logic                  boost_active;
        logic [7:0]            rdata;
        logic [7:0]            vout_eff;
        logic                  analog_en;
        logic                  boost_run;
        logic                  low_current;
        logic                  led_blank;
        logic                  autoload;
    } lpms_top_t;

    localparam logic [lpms_pkg::CNT_W-1:0] STARTUP_LAST = lpms_pkg::CNT_W'(STARTUP_CYCLES - 1);
    localparam logic [lpms_pkg::CNT_W-1:0] SOFT_LAST    = lpms_pkg::CNT_W'(SOFTSTART_CYCLES - 1);

    lpms_top_t r;
    lpms_top_t next_r;
    logic      stby_exit;
    logic      boost_en;
    logic      thermal_trip;
    logic      in_reset;
    logic      sw_on;

    function automatic logic [7:0] lpms_clamp(input logic [7:0] code);
        if (code < lpms_pkg::VOUT_MIN) begin
            return lpms_pkg::VOUT_MIN;
        end else if (code > lpms_pkg::VOUT_MAX) begin
            return lpms_pkg::VOUT_MAX;
        end
        return code;
    endfunction : lpms_clamp

    assign stby_exit = r.mode_reg[lpms_pkg::MODE_STBY_EXIT];
    assign boost_en  = r.mode_reg[lpms_pkg::MODE_BOOST_EN];
    assign thermal_trip       = r.tsd_sync[1];
    assign in_reset  = !r.rst_sync[1];

    always_comb begin
        next_r          = r;
        next_r.rst_sync = {r.rst_sync[0], EXT_RESET_PIN_N};
        next_r.tsd_sync = {r.tsd_sync[0], THERMAL_TRIP};
        next_r.pk_sync  = {r.pk_sync[0], PEAK_REACHED};
        next_r.oc_sync  = {r.oc_sync[0], OVERCURRENT};

        // registers; a write outside the pin reset lands at once, in any order; the mode register keeps only bits 2:0
        if (REG_WR && !in_reset) begin
            unique case (REG_ADDR)
                lpms_pkg::ADDR_VOUT: next_r.vout_reg = REG_WDATA;
                lpms_pkg::ADDR_MODE: next_r.mode_reg = REG_WDATA & lpms_pkg::MODE_MASK;
                default: ;
            endcase
        end
        if (REG_RD) begin
            unique case (REG_ADDR)
                lpms_pkg::ADDR_VOUT:   next_r.rdata = r.vout_reg;
                lpms_pkg::ADDR_MODE:   next_r.rdata = r.mode_reg;
                lpms_pkg::ADDR_STATUS: next_r.rdata = {3'h0, r.state};
                default:               next_r.rdata = 8'h00;
            endcase
        end

        // delays are oscillator cycle counts
        unique case (r.state)
            lpms_pkg::ST_RESET: begin
                next_r.state = lpms_pkg::ST_STANDBY;
                next_r.cnt   = '0;
            end
            lpms_pkg::ST_STANDBY: begin
                next_r.cnt          = '0;
                next_r.boost_active = 1'b0;
                if (stby_exit) begin
                    next_r.state = lpms_pkg::ST_STARTUP;
                end
            end
            lpms_pkg::ST_STARTUP: begin
                if (!stby_exit) begin
                    next_r.state = lpms_pkg::ST_STANDBY;
                end else if (thermal_trip) begin
                    next_r.cnt = '0;
                end else if (r.cnt == STARTUP_LAST) begin
                    next_r.cnt   = '0;
                    next_r.state = boost_en ? lpms_pkg::ST_BOOST_START : lpms_pkg::ST_NORMAL;
                end else begin
                    next_r.cnt = r.cnt + 1'b1;
                end
            end
            lpms_pkg::ST_BOOST_START: begin
                if (!stby_exit) begin
                    next_r.state = lpms_pkg::ST_STANDBY;
                end else if (thermal_trip) begin
                    next_r.state = lpms_pkg::ST_STARTUP;
                    next_r.cnt   = '0;
                end else if (!boost_en) begin
                    next_r.state = lpms_pkg::ST_NORMAL;
                end else if (r.cnt == SOFT_LAST) begin
                    next_r.state        = lpms_pkg::ST_NORMAL;
                    next_r.boost_active = 1'b1;
                end else begin
                    next_r.cnt = r.cnt + 1'b1;
                end
            end
            lpms_pkg::ST_NORMAL: begin
                next_r.cnt = '0;
                if (!boost_en) begin
                    next_r.boost_active = 1'b0;
                end
                if (!stby_exit) begin
                    next_r.state = lpms_pkg::ST_STANDBY;
                end else if (thermal_trip) begin
                    next_r.state        = lpms_pkg::ST_STARTUP;
                    next_r.boost_active = 1'b0;
                end else if (boost_en && !r.boost_active) begin
                    next_r.state = lpms_pkg::ST_BOOST_START;
                end
            end
            default: begin
                next_r.state = lpms_pkg::ST_RESET;
            end
        endcase

        // registered outputs follow the next state
        next_r.analog_en   = (next_r.state == lpms_pkg::ST_STARTUP) ||
                             (next_r.state == lpms_pkg::ST_BOOST_START) ||
                             (next_r.state == lpms_pkg::ST_NORMAL);
        next_r.low_current = (next_r.state == lpms_pkg::ST_BOOST_START);
        next_r.led_blank   = (next_r.state == lpms_pkg::ST_BOOST_START);
        next_r.boost_run   = next_r.low_current ||
                             ((next_r.state == lpms_pkg::ST_NORMAL) && next_r.boost_active);
        next_r.autoload    = next_r.analog_en && next_r.mode_reg[lpms_pkg::MODE_AUTOLOAD];
        next_r.vout_eff    = lpms_clamp(next_r.vout_reg);

        // internal reset from the synchronised pin wins over everything
        if (in_reset) begin
            next_r              = '0;
            next_r.rst_sync     = {r.rst_sync[0], EXT_RESET_PIN_N};
            next_r.tsd_sync     = {r.tsd_sync[0], THERMAL_TRIP};
            next_r.pk_sync      = {r.pk_sync[0], PEAK_REACHED};
            next_r.oc_sync      = {r.oc_sync[0], OVERCURRENT};
            next_r.state        = lpms_pkg::ST_RESET;
            next_r.vout_reg     = lpms_pkg::VOUT_RESET;
            next_r.mode_reg     = lpms_pkg::MODE_RESET;
            next_r.vout_eff     = lpms_pkg::VOUT_RESET;
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            r          <= '0;
            r.state    <= lpms_pkg::ST_RESET;
            r.vout_reg <= lpms_pkg::VOUT_RESET;
            r.mode_reg <= lpms_pkg::MODE_RESET;
            r.vout_eff <= lpms_pkg::VOUT_RESET;
        end else begin
            r <= next_r;
        end
    end

    // skipping allowed only once the active load is off
    lpms_pulse_gen u_pulse (
        .clk         (REF_CLK),
        .arst_n      (ARST_N),
        .enable      (r.boost_run),
        .low_current (r.low_current),
        .skip_ok     (!r.autoload),
        .peak        (r.pk_sync[1]),
        .overcurrent (r.oc_sync[1]),
        .sw_on       (sw_on)
    );

    assign REG_RDATA         = r.rdata;
    assign MODE_STATE        = r.state;
    assign ANALOG_EN         = r.analog_en;
    assign BOOST_RUN         = r.boost_run;
    assign BOOST_LOW_CURRENT = r.low_current;
    assign BOOST_SW          = sw_on;
    assign LED_BLANK         = r.led_blank;
    assign ACTIVE_LOAD_EN    = r.autoload;
    assign VOUT_CODE         = r.vout_eff;

    a_reset_hold: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        in_reset |=> (r.state == lpms_pkg::ST_RESET) && (r.mode_reg == lpms_pkg::MODE_RESET))
        else $error("reset did not clear state");
    a_standby_stay: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (!in_reset && r.state == lpms_pkg::ST_STANDBY && !stby_exit) |=> (r.state == lpms_pkg::ST_STANDBY) && !ANALOG_EN)
        else $error("left standby without exit bit");
    a_startup_wait: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (r.state == lpms_pkg::ST_STARTUP && r.cnt != STARTUP_LAST) |=>
        (r.state != lpms_pkg::ST_NORMAL) && (r.state != lpms_pkg::ST_BOOST_START))
        else $error("startup delay cut short");
    a_thermal_fall: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (!in_reset && thermal_trip && stby_exit && (r.state == lpms_pkg::ST_NORMAL ||
         r.state == lpms_pkg::ST_STARTUP || r.state == lpms_pkg::ST_BOOST_START)) |=> r.state == lpms_pkg::ST_STARTUP)
        else $error("thermal trip did not hold startup");
    a_led_blank: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (r.state == lpms_pkg::ST_BOOST_START) |-> LED_BLANK && BOOST_LOW_CURRENT)
        else $error("LEDs not blanked in soft start");
    a_vout_clamp: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (VOUT_CODE >= lpms_pkg::VOUT_MIN) && (VOUT_CODE <= lpms_pkg::VOUT_MAX))
        else $error("voltage code out of range");
    a_boost_entry: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (!in_reset && r.state == lpms_pkg::ST_NORMAL && stby_exit && !thermal_trip && boost_en && !r.boost_active)
        |=> r.state == lpms_pkg::ST_BOOST_START)
        else $error("boost enable did not start soft start");
    a_boost_stop: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (r.state == lpms_pkg::ST_NORMAL && !boost_en) |=> !BOOST_RUN)
        else $error("boost ran with enable cleared");
    a_load_off: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        !r.mode_reg[lpms_pkg::MODE_AUTOLOAD] |-> !ACTIVE_LOAD_EN)
        else $error("active load on with bit cleared");

    // sequencing; the pin reset wins, so each state-exit step names !in_reset
    a_reset_out: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        in_reset |=> !ANALOG_EN && !BOOST_RUN && !LED_BLANK && (VOUT_CODE == lpms_pkg::VOUT_RESET))
        else $error("outputs not cleared by reset");
    a_exit_standby: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (!in_reset && r.state == lpms_pkg::ST_STANDBY && stby_exit)
        |=> (r.state == lpms_pkg::ST_STARTUP) && ANALOG_EN)
        else $error("standby exit did not start up");
    a_standby_quiet: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (r.state == lpms_pkg::ST_STANDBY) |-> !ANALOG_EN && !BOOST_RUN && !ACTIVE_LOAD_EN && !LED_BLANK)
        else $error("function active in standby");
    a_startup_exit: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (!in_reset && r.state == lpms_pkg::ST_STARTUP && stby_exit && !thermal_trip && r.cnt == STARTUP_LAST)
        |=> (r.state == ($past(boost_en) ? lpms_pkg::ST_BOOST_START : lpms_pkg::ST_NORMAL)))
        else $error("startup exit ignored boost enable");
    a_thermal_quiet: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (r.state == lpms_pkg::ST_STARTUP) |-> !BOOST_RUN && !LED_BLANK)
        else $error("boost ran during startup");
    a_soft_len: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (!in_reset && r.state == lpms_pkg::ST_BOOST_START && stby_exit && !thermal_trip && boost_en && r.cnt != SOFT_LAST)
        |=> (r.state == lpms_pkg::ST_BOOST_START) && LED_BLANK)
        else $error("soft start cut short");
    a_boost_quit: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (!in_reset && r.state == lpms_pkg::ST_BOOST_START && stby_exit && !thermal_trip && !boost_en)
        |=> (r.state == lpms_pkg::ST_NORMAL) && !BOOST_RUN)
        else $error("boost enable clear ignored in soft start");
    a_normal_lit: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (r.state == lpms_pkg::ST_NORMAL) |-> !LED_BLANK && !BOOST_LOW_CURRENT)
        else $error("blanking held in normal mode");
    a_analog_on: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (r.state == lpms_pkg::ST_NORMAL || r.state == lpms_pkg::ST_BOOST_START) |-> ANALOG_EN)
        else $error("analog blocks off while running");

    // register file
    a_vout_write: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (REG_WR && !in_reset && REG_ADDR == lpms_pkg::ADDR_VOUT) |=> r.vout_reg == $past(REG_WDATA))
        else $error("voltage code write lost");
    a_mode_write: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (REG_WR && !in_reset && REG_ADDR == lpms_pkg::ADDR_MODE)
        |=> r.mode_reg == ($past(REG_WDATA) & lpms_pkg::MODE_MASK))
        else $error("mode write lost");
endmodule : lpms_top
